// >>> core/tls_slave.sv
// serial slave holding the two alarm limits, alert query and general call
// assumes scl/sda/address pins are asynchronous and the limit events,
// mode and resolution inputs come from logic on mclk_in
`include "tls_cfg.svh"
module tls_slave #(
  parameter int unsigned TOUT_CYC = `TLS_TOUT_US * `TLS_CLK_MHZ
) (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic [2:0]  address_pins_in,
  input  wire logic [1:0]  resolution_select_in,
  input  wire logic        alarm_polarity_in,
  input  wire logic        thermostat_mode_select_in,
  input  wire logic        high_event_in,
  input  wire logic        low_event_in,
  output logic             alert_out,
  output logic             fault_clear_out,
  output logic             busy_out,
  output logic [15:0]      low_limit_out,
  output logic [15:0]      high_limit_out
);
  import tls_pkg::*;

  localparam logic [`TLS_TOUT_W-1:0] TOUT_LIM =
    `TLS_TOUT_W'(TOUT_CYC);
  localparam logic [`TLS_POR_W-1:0] POR_CNT =
    `TLS_POR_W'(`TLS_POR_CYC);
  localparam logic [`TLS_POR_W-1:0] POR_LAST = `TLS_POR_W'(1);

  // synchronisers start at the idle bus level so reset makes no false edge
  localparam tls_state_t RST = '{
    scl_s1:  1'b1,
    scl_s2:  1'b1,
    scl_s3:  1'b1,
    sda_s1:  1'b1,
    sda_s2:  1'b1,
    sda_s3:  1'b1,
    st:      TLS_IDLE,
    ph:      TLS_ADDR,
    low:     `TLS_LOW_RST,
    high:    `TLS_HIGH_RST,
    alert:   1'b1,
    busy:    POR_CNT,
    default: '0
  };

  tls_state_t q;
  tls_state_t d;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        smb_on;
  logic        alarm_act;
  logic [15:0] rword;
  logic [15:0] wval;

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    res_mask = ~(`TLS_MASK9 >> res);
  endfunction

  assign scl_rise  = q.scl_s2 & ~q.scl_s3;
  assign scl_fall  = ~q.scl_s2 & q.scl_s3;
  assign start_det = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
  assign stop_det  = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
  assign smb_on    = thermostat_mode_select_in & ~alarm_polarity_in;
  // interrupt mode holds a pending flag, comparator mode follows events
  assign alarm_act = thermostat_mode_select_in ? q.pend : q.cmp_act;
  assign rword = (q.ptr == `TLS_PTR_LOW)  ? q.low & res_mask(resolution_select_in) :
                 (q.ptr == `TLS_PTR_HIGH) ? q.high & res_mask(resolution_select_in) :
                 16'h0000;
  assign wval = {q.dhi, q.sh} & res_mask(resolution_select_in);

  always_comb begin
    d = q;
    d.fclr    = 1'b0;
    d.scl_s1  = scl_in;
    d.scl_s2  = q.scl_s1;
    d.scl_s3  = q.scl_s2;
    d.sda_s1  = sda_in;
    d.sda_s2  = q.sda_s1;
    d.sda_s3  = q.sda_s2;
    d.apin_s1 = address_pins_in;
    d.apin_s2 = q.apin_s1;

    // busy after reset; the address is taken once the pins have settled
    if (q.busy != '0) begin
      d.busy = q.busy - POR_LAST;
      if (q.busy == POR_LAST) begin
        d.addr = q.apin_s2;
      end
    end

    if (start_det && q.busy == '0) begin
      // a repeated start drops any partial write
      d.st     = TLS_RX;
      d.ph     = TLS_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
      d.rd     = 1'b0;
      d.ara    = 1'b0;
    end else if (stop_det) begin
      d.st     = TLS_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        TLS_RX: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], q.sda_s2};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == `TLS_BYTE_BITS) begin
            d.cnt    = 4'h0;
            d.st     = TLS_RACK;
            d.sda_oe = 1'b1;
            case (q.ph)
              TLS_ADDR: begin
                if (q.sh == {`TLS_DEV_ID, q.addr, 1'b1}) begin
                  d.rd      = 1'b1;
                  d.tx      = rword[15:8];
                  d.lo_byte = 1'b0;
                end else if (q.sh == {`TLS_DEV_ID, q.addr, 1'b0}) begin
                  d.ph = TLS_PTR;
                end else if (q.sh == `TLS_ARA_CODE && smb_on && q.pend) begin
                  d.rd  = 1'b1;
                  d.ara = 1'b1;
                  d.tx  = {`TLS_DEV_ID, q.addr, q.lim};
                end else if (q.sh == `TLS_GC_ADDR) begin
                  d.ph = TLS_GCMD;
                end else begin
                  d.st     = TLS_WAIT;
                  d.sda_oe = 1'b0;
                end
              end
              TLS_PTR: begin
                d.ptr = q.sh;
                d.ph  = TLS_D0;
              end
              TLS_D0: begin
                d.dhi = q.sh;
                d.ph  = TLS_D1;
              end
              TLS_D1: begin
                // only a complete second byte reaches the register
                if (q.ptr == `TLS_PTR_LOW) begin
                  d.low  = wval;
                  d.fclr = (wval != q.low);
                end else if (q.ptr == `TLS_PTR_HIGH) begin
                  d.high = wval;
                  d.fclr = (wval != q.high);
                end
                d.ph = TLS_SKIP;
              end
              TLS_GCMD: begin
                if (q.sh == `TLS_GC_LATCH) begin
                  d.addr = q.apin_s2;
                end else if (q.sh == `TLS_GC_RESET) begin
                  d.low     = `TLS_LOW_RST;
                  d.high    = `TLS_HIGH_RST;
                  d.ptr     = 8'h00;
                  d.pend    = 1'b0;
                  d.cmp_act = 1'b0;
                  d.busy    = POR_CNT;
                  d.fclr    = 1'b1;
                end
                d.ph = TLS_SKIP;
              end
              TLS_SKIP: begin
                // acked but dropped
                d.ph = TLS_SKIP;
              end
              default: begin
                d.st     = TLS_WAIT;
                d.sda_oe = 1'b0;
              end
            endcase
          end
        end
        TLS_RACK: begin
          if (scl_fall) begin
            d.st     = q.rd ? TLS_TX : TLS_RX;
            d.sda_oe = q.rd & ~q.tx[7];
            d.cnt    = 4'h0;
          end
        end
        TLS_TX: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
            // released a one but the bus reads zero: lower address wins
            if (q.ara && !q.sda_oe && !q.sda_s2) begin
              d.st = TLS_WAIT;
            end
          end else if (scl_fall) begin
            if (q.cnt == `TLS_BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.st     = TLS_TACK;
              if (q.ara) begin
                d.pend = 1'b0;
              end
            end else begin
              d.tx     = {q.tx[6:0], 1'b0};
              d.sda_oe = ~q.tx[6];
            end
          end
        end
        TLS_TACK: begin
          if (scl_rise) begin
            if (q.sda_s2 || q.ara) begin
              d.st = TLS_WAIT;
            end else begin
              d.tx      = q.lo_byte ? rword[15:8] : rword[7:0];
              d.lo_byte = ~q.lo_byte;
              d.st      = TLS_RACK;
            end
          end
        end
        TLS_WAIT: begin
          d.sda_oe = 1'b0;
        end
        TLS_IDLE: begin
          d.sda_oe = 1'b0;
        end
        default: begin
          d.st     = TLS_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // scl timeout: count low time, saturate, then drop the transfer
    if (!q.scl_s2) begin
      if (q.tout != TOUT_LIM) begin
        d.tout = q.tout + `TLS_TOUT_W'(1);
      end
    end else begin
      d.tout = '0;
    end
    if (q.tout == TOUT_LIM) begin
      d.st     = TLS_IDLE;
      d.sda_oe = 1'b0;
    end

    // events come after the query clear so that a new event wins
    if (high_event_in) begin
      d.cmp_act = 1'b1;
      if (thermostat_mode_select_in) begin
        d.pend = 1'b1;
        d.lim  = 1'b1;
      end
    end else if (low_event_in) begin
      d.cmp_act = 1'b0;
      if (thermostat_mode_select_in) begin
        d.pend = 1'b1;
        d.lim  = 1'b0;
      end
    end

    d.alert = ~(alarm_act ^ alarm_polarity_in);
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign sda_out         = 1'b0;
  assign sda_oe_out      = q.sda_oe;
  assign alert_out       = q.alert;
  assign fault_clear_out = q.fclr;
  assign busy_out        = (q.busy != '0);
  assign low_limit_out   = q.low;
  assign high_limit_out  = q.high;
endmodule

// >>> common/tls_cfg.svh
// constants for the temperature limit serial slave
// assumes a 100 MHz system clock and open-drain SCL/SDA pins
// Behaviour
// - Low and high limits are 16-bit two's complement, bit 15 is sign.
// - Limit writes keep only the selected resolution bits, lower bits zero.
// - Limit reads return sign and resolution bits, lower bits as zero.
// - Write: address with write bit, pointer 02h or 03h, two data bytes.
// - Data bytes after the second in one write are ignored.
// - Stop or repeated start before two data bytes discards the data.
// - Pointer stays on the written limit for later reads.
// - Read: address with read bit, upper byte, master ack, lower byte.
// - Master ack after the lower byte restarts from the upper byte.
// - Reset loads low limit 4B00h and high limit 5000h.
// - Changing either limit clears the consecutive fault counter.
// - Alert query answered only in interrupt mode with active-low polarity.
// - Alert query 00011001: pending device acks and sends its address.
// - Eighth bit of the query answer: one high limit, zero low limit.
// - Lowest address wins; winner releases alert after sending address.
// - Loser does not ack further and keeps alert asserted.
// - SCL low past the timeout resets the interface and releases SDA.
// - General call acknowledged only for an all-zero first byte.
// - General call command 04h re-samples the address pins.
// - General call 06h re-samples pins, resets registers, stays busy.
// - Resolution select 00..11 gives 9..12 data bits, default 9.
// - Alarm polarity zero means active low, one active high.
// - Thermostat mode zero is comparator, one is interrupt.
`ifndef TLS_CFG_SVH
`define TLS_CFG_SVH
`define TLS_PTR_LOW   8'h02
`define TLS_PTR_HIGH  8'h03
`define TLS_LOW_RST   16'h4B00
`define TLS_HIGH_RST  16'h5000
`define TLS_MASK9     16'h007F
`define TLS_DEV_ID    4'h9
`define TLS_ARA_CODE  8'h19
`define TLS_GC_ADDR   8'h00
`define TLS_GC_LATCH  8'h04
`define TLS_GC_RESET  8'h06
`define TLS_BYTE_BITS 4'h8
`define TLS_CLK_MHZ   100
`define TLS_TOUT_US   25
`define TLS_TOUT_W    22
`define TLS_POR_NS    1000
`define TLS_POR_CYC   ((`TLS_POR_NS * `TLS_CLK_MHZ) / 1000)
`define TLS_POR_W     8
`endif

// >>> common/tls_pkg.sv
// types for the temperature limit serial slave
// assumes tls_cfg.svh is on the include path
`include "tls_cfg.svh"
package tls_pkg;
  typedef enum logic [2:0] {
    TLS_IDLE = 3'h0,
    TLS_RX   = 3'h1,
    TLS_RACK = 3'h3,
    TLS_TX   = 3'h2,
    TLS_TACK = 3'h6,
    TLS_WAIT = 3'h7
  } tls_st_t;

  typedef enum logic [2:0] {
    TLS_ADDR = 3'h0,
    TLS_PTR  = 3'h1,
    TLS_D0   = 3'h3,
    TLS_D1   = 3'h2,
    TLS_SKIP = 3'h6,
    TLS_GCMD = 3'h7
  } tls_ph_t;

  typedef struct packed {
    logic                   scl_s1;
    logic                   scl_s2;
    logic                   scl_s3;
    logic                   sda_s1;
    logic                   sda_s2;
    logic                   sda_s3;
    logic [2:0]             apin_s1;
    logic [2:0]             apin_s2;
    logic [2:0]             addr;
    tls_st_t                st;
    tls_ph_t                ph;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic [7:0]             tx;
    logic                   rd;
    logic                   ara;
    logic                   lo_byte;
    logic [7:0]             ptr;
    logic [7:0]             dhi;
    logic [15:0]            low;
    logic [15:0]            high;
    logic                   pend;
    logic                   lim;
    logic                   cmp_act;
    logic                   sda_oe;
    logic                   alert;
    logic                   fclr;
    logic [`TLS_TOUT_W-1:0] tout;
    logic [`TLS_POR_W-1:0]  busy;
  } tls_state_t;
endpackage

// >>> test/tls_slave_props.sv
// port checker for tls_slave
// assumes one clock domain and an async active-low reset
module tls_slave_props #(
  parameter int unsigned TOUT_CYC = 2000
) (
  input wire logic        mclk_in,
  input wire logic        resetn_in,
  input wire logic        scl_in,
  input wire logic        sda_oe_out,
  input wire logic        alarm_polarity_in,
  input wire logic        thermostat_mode_select_in,
  input wire logic        high_event_in,
  input wire logic        low_event_in,
  input wire logic        alert_out,
  input wire logic        fault_clear_out,
  input wire logic        busy_out,
  input wire logic [15:0] low_limit_out,
  input wire logic [15:0] high_limit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [31:0] low_run_q;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in)
      low_run_q <= 32'h0;
    else if (scl_in)
      low_run_q <= 32'h0;
    else
      low_run_q <= low_run_q + 32'h1;
  end
  sequence s_hi_cmp;
    high_event_in && !thermostat_mode_select_in && !busy_out;
  endsequence
  sequence s_lo_cmp;
    low_event_in && !high_event_in && !thermostat_mode_select_in
      && !busy_out;
  endsequence
  // the event lands in the alarm level first, the pin follows a cycle later
  sequence s_cmp_hold;
    !thermostat_mode_select_in;
  endsequence
  property p_rst_val;
    $rose(resetn_in) |-> low_limit_out == 16'h4B00
      && high_limit_out == 16'h5000;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("limits not at reset value");
  property p_busy_hold;
    $rose(resetn_in) |-> busy_out [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  property p_lsb;
    low_limit_out[3:0] == 4'h0 && high_limit_out[3:0] == 4'h0;
  endproperty
  a_lsb: assert property (p_lsb)
    else $error("limit low bits set");
  property p_clr_pulse;
    fault_clear_out |=> !fault_clear_out;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse)
    else $error("fault clear too long");
  property p_clr_chg;
    $changed(low_limit_out) || $changed(high_limit_out)
      |-> ##[0:1] (fault_clear_out || busy_out);
  endproperty
  a_clr_chg: assert property (p_clr_chg)
    else $error("limit changed without fault clear");
  property p_cmp_set;
    s_hi_cmp ##1 s_cmp_hold |=> alert_out == $past(alarm_polarity_in);
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("alarm not raised");
  property p_cmp_clr;
    s_lo_cmp ##1 s_cmp_hold |=> alert_out == !$past(alarm_polarity_in);
  endproperty
  a_cmp_clr: assert property (p_cmp_clr)
    else $error("alarm not cleared");
  // margin of 8 covers the pin synchroniser
  property p_tout;
    low_run_q > TOUT_CYC + 8 |-> !sda_oe_out;
  endproperty
  a_tout: assert property (p_tout)
    else $error("sda held past timeout");
endmodule
bind tls_slave tls_slave_props #(.TOUT_CYC(TOUT_CYC)) i_props (
  .mclk_in, .resetn_in, .scl_in, .sda_oe_out, .alarm_polarity_in,
  .thermostat_mode_select_in, .high_event_in, .low_event_in,
  .alert_out, .fault_clear_out, .busy_out, .low_limit_out,
  .high_limit_out);

// >>> test/tls_master_model.sv
// i2c master model driving scl at 125 ns per bit
// assumes sda_in is the resolved wire with a pull-up
module tls_master_model (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real Q = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // sda moves only while scl is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    sda_low_out = !b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b0;
    #Q;
  endtask
endmodule

// >>> test/tb_tls_slave.sv
// self-checking bench for tls_slave
// assumes tls_master_model owns scl and pulls sda low
`include "tls_cfg.svh"
module tb_tls_slave;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        alarm_polarity = 1'b0;
  logic        mode = 1'b0;
  logic        hev = 1'b0;
  logic        lev = 1'b0;
  logic [1:0]  res = 2'h0;
  logic [2:0]  pins = 3'h5;
  logic        scl, sda_low, sda_oe, sda_o, alert, fclr, busy;
  logic [15:0] lo, hi;
  wire         sda = !(sda_low || (sda_oe && !sda_o));
  int          errors = 0;
  int          n_checks = 0;
  int          n_fclr = 0;
  always #5 clk = !clk;
  always @(negedge clk)
    if (fclr === 1'b1)
      n_fclr++;
  tls_master_model i_m (.sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  tls_slave #(.TOUT_CYC(2000)) i_dut (
    .mclk_in(clk), .resetn_in(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .address_pins_in(pins),
    .resolution_select_in(res), .alarm_polarity_in(alarm_polarity),
    .thermostat_mode_select_in(mode), .high_event_in(hev),
    .low_event_in(lev), .alert_out(alert), .fault_clear_out(fclr),
    .busy_out(busy), .low_limit_out(lo), .high_limit_out(hi));
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {4'h9, pins, rw};
  endfunction
  task automatic wb(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic       r;
    i_m.xfer(d, q);
    i_m.bitx(1'b1, r);
    chk("ack", 16'(!r), 16'(ea));
  endtask
  task automatic rb(input logic [7:0] e, input logic ma);
    logic [7:0] q;
    logic       r;
    i_m.xfer(8'hFF, q);
    i_m.bitx(!ma, r);
    chk("rd", 16'(q), 16'(e));
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    i_m.start();
    wb(adr(1'b0), 1'b1);
    wb(p, 1'b1);
    wb(v[15:8], 1'b1);
    wb(v[7:0], 1'b1);
    i_m.stop();
  endtask
  task automatic rd(input logic [15:0] v);
    i_m.start();
    wb(adr(1'b1), 1'b1);
    rb(v[15:8], 1'b1);
    rb(v[7:0], 1'b0);
    i_m.stop();
  endtask
  task automatic ara(input logic ea, input logic [7:0] e);
    i_m.start();
    wb(8'h19, ea);
    if (ea)
      rb(e, 1'b0);
    i_m.stop();
  endtask
  task automatic pulse(input logic h);
    @(negedge clk);
    hev = h;
    lev = !h;
    @(negedge clk);
    hev = 1'b0;
    lev = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic idle();
    for (int k = 0; k < 300 && busy !== 1'b0; k++)
      @(negedge clk);
    chk("busy", 16'(busy), 16'h0);
    if (busy !== 1'b0)
      complete_run();
    repeat (5) @(negedge clk);
  endtask
  initial begin
    logic [7:0] q;
    logic       r;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    idle();
    chk("low", lo, `TLS_LOW_RST);
    chk("high", hi, `TLS_HIGH_RST);
    wr(8'h02, 16'h4B00);
    rd(16'h4B00);
    ara(1'b0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      res = 2'(k);
      wr(8'h03, 16'h7FFF);
      // 9 + k bits kept, the 7 - k lowest read as zero
      chk("high", hi, 16'h7FFF & (16'hFFFF << (7 - k)));
      rd(16'h7FFF & (16'hFFFF << (7 - k)));
    end
    chk("fclr", 16'(n_fclr), 16'h4);
    i_m.start();
    wb(adr(1'b0), 1'b1);
    wb(8'h02, 1'b1);
    wb(8'hC3, 1'b1);
    wb(8'hA5, 1'b1);
    wb(8'h11, 1'b1);
    i_m.stop();
    chk("low", lo, 16'hC3A0);
    i_m.start();
    wb(adr(1'b0), 1'b1);
    wb(8'h02, 1'b1);
    wb(8'h55, 1'b1);
    i_m.start();
    wb(adr(1'b1), 1'b1);
    rb(8'hC3, 1'b1);
    rb(8'hA0, 1'b1);
    rb(8'hC3, 1'b1);
    rb(8'hA0, 1'b0);
    i_m.stop();
    chk("low", lo, 16'hC3A0);
    pulse(1'b1);
    chk("alert", 16'(alert), 16'h0);
    ara(1'b0, 8'h00);
    pulse(1'b0);
    chk("alert", 16'(alert), 16'h1);
    mode = 1'b1;
    alarm_polarity = 1'b1;
    pulse(1'b1);
    ara(1'b0, 8'h00);
    @(negedge clk);
    alarm_polarity = 1'b0;
    pulse(1'b1);
    i_m.start();
    wb(8'h19, 1'b1);
    i_m.xfer(8'h91, q);
    i_m.bitx(1'b1, r);
    i_m.stop();
    chk("alert", 16'(alert), 16'h0);
    ara(1'b1, {4'h9, pins, 1'b1});
    chk("alert", 16'(alert), 16'h1);
    ara(1'b0, 8'h00);
    pulse(1'b0);
    ara(1'b1, {4'h9, pins, 1'b0});
    i_m.start();
    i_m.xfer(adr(1'b0), q);
    repeat (2) @(negedge clk);
    chk("oe", 16'(sda_oe), 16'h1);
    repeat (2100) @(negedge clk);
    chk("oe", 16'(sda_oe), 16'h0);
    i_m.stop();
    rd(16'hC3A0);
    i_m.start();
    wb(8'h01, 1'b0);
    i_m.stop();
    @(negedge clk);
    pins = 3'h2;
    i_m.start();
    wb(8'h00, 1'b1);
    wb(8'h04, 1'b1);
    i_m.stop();
    ara(1'b0, 8'h00);
    i_m.start();
    wb(8'h9A, 1'b0);
    i_m.stop();
    rd(16'hC3A0);
    i_m.start();
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    i_m.stop();
    chk("busy", 16'(busy), 16'h1);
    idle();
    chk("low", lo, `TLS_LOW_RST);
    chk("high", hi, `TLS_HIGH_RST);
    complete_run();
  end
endmodule
